//--- hw/sdc_pkg.sv
// Purpose: Constants and types for the codec channel filter path
// Assumes: SYS_CLK is the master clock, eight times the modulator rate; APB register access
// Notes:   One rule to a line below, each tag as used in the logic
// Overview of operation
// - The decimator takes one modulator bit every eighth clock.
// - The decimator is a three-stage sinc-cubed filter whose ratio is 32 to 256 by rate.
// - At ratio 32 each stage grows five bits and the 16-bit word ends in one zero bit.
// - At lower rates the wider decimator result is truncated to the 16-bit word.
// - The ADC word is twos complement and truncated to 16 bits in data mode.
// - Input at or above positive full scale gives the saturated code 0x7fff.
// - Mixed mode keeps 15 bits and uses the word's top bit as the control-or-data flag.
// - DAC words are twos complement with 0x7fff full positive and 0x8000 full negative.
// - The interpolator raises DAC words to the one-eighth clock rate with the same sinc-cubed form.
// - One DAC word is taken per sample period and the last one is reused if none came.
// - Setting the bypass bit 5 of the filter control register skips the interpolator.
// - A digital sigma-delta modulator turns the 16-bit data into a 1-bit stream at one eighth clock.
// - Gain field bits 2..0 select 0, 6, 12, 18, 20, 26, 32 or 38 dB of encoder gain.
// - Rates of 64, 32, 16 or 8 kHz are offered, scaled from a 16.384 MHz master clock.
// - Data mode needs mode bit 0 set and mixed mode needs bits 0 and 1 set.
package sdc_pkg;
   // Register byte offsets
   localparam logic [7:0] SDC_SERIAL_MODE_OFF = 8'h00;
   localparam logic [7:0] SDC_RATE_OFF        = 8'h04;
   localparam logic [7:0] SDC_GAIN_CTRL_OFF   = 8'h08;
   localparam logic [7:0] SDC_FILT_CTRL_OFF   = 8'h0c;
   localparam logic [7:0] SDC_ADC_DATA_OFF    = 8'h10;
   localparam logic [7:0] SDC_DAC_DATA_OFF    = 8'h14;
   localparam logic [7:0] SDC_STATUS_OFF      = 8'h18;
   // Field positions
   localparam int SDC_MODE_DATA_BIT  = 0;
   localparam int SDC_MODE_MIXED_BIT = 1;
   localparam int SDC_BYPASS_BIT     = 5;
   localparam int SDC_OVR_BIT        = 0;
   localparam int SDC_GAIN_DB_LSB    = 8;
   // Timing: modulator runs at clock over eight
   localparam logic [2:0] SDC_MOD_DIV_LAST = 3'h7;
   localparam int SDC_MCLK_KHZ = 16384;
   // Word widths and fixed codes
   localparam logic [15:0] SDC_POS_FS = 16'h7fff;
   localparam logic [15:0] SDC_NEG_FS = 16'h8000;
   localparam logic [17:0] SDC_SDM_POS = 18'h07fff;
   localparam logic [17:0] SDC_SDM_NEG = 18'h38000;
   // Reset values
   localparam logic [1:0] SDC_RATE_RST = 2'h0;
   localparam logic [2:0] SDC_GAIN_RST = 3'h0;
   localparam logic [7:0] SDC_GAIN_DB_TABLE [8] = '{8'd0, 8'd6, 8'd12, 8'd18, 8'd20, 8'd26, 8'd32, 8'd38};
   typedef enum logic [1:0] {SDC_R64K, SDC_R32K, SDC_R16K, SDC_R8K} sdc_rate_t;
endpackage : sdc_pkg

//--- hw/sdc_filter_path.sv
// Purpose: Sinc-cubed decimator, interpolator and sigma-delta modulator of one channel
// Assumes: All inputs synchronous to SYS_CLK; APB slave with zero-wait access phase
// Notes:   The decimator cannot stall, so a full output buffer drops a word and flags it
//          Rates are SYS_CLK over 8N, so a 20 MHz clock runs about 22 percent above the nominal rates
`timescale 1ns/1ps
module sdc_filter_path
   import sdc_pkg::*;
(
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        SRST,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic [31:0]      PRDATA,
   // Modulator and DAC side
   input  wire logic        MOD_BIT,
   output logic             DAC_BIT,
   output logic [2:0]       GAIN_SEL,
   // Host serial port side
   output logic [15:0]      ADC_WORD,
   output logic             ADC_VALID,
   input  wire logic        ADC_READY,
   input  wire logic [15:0] DAC_WORD,
   input  wire logic        DAC_VALID,
   output logic             DAC_READY,
   output logic             SAMPLE_TICK
);

   // Decimator words are 26 bits so 256 cubed fits with headroom; interpolator words are
   // 34 bits so full scale times 256 squared never wraps. All state lives in this one
   // struct so reset and the next-state copy cannot miss a field.
   typedef struct packed {
      logic               mode_data;
      logic               mode_mixed;
      logic [1:0]         rate;
      logic [2:0]         gain;
      logic               bypass;
      logic [2:0]         div;
      logic [7:0]         dec_cnt;
      logic [25:0]        di1;
      logic [25:0]        di2;
      logic [25:0]        di3;
      logic [25:0]        dd1;
      logic [25:0]        dd2;
      logic [25:0]        dd3;
      logic [15:0]        adc_word;
      logic [1:0][15:0]   fifo;
      logic               wr_ptr;
      logic               rd_ptr;
      logic [1:0]         count;
      logic               overrun;
      logic [15:0]        dac_hold;
      logic [15:0]        dac_cur;
      logic [33:0]        cd1;
      logic [33:0]        cd2;
      logic [33:0]        cd3;
      logic [33:0]        ii1;
      logic [33:0]        ii2;
      logic [33:0]        ii3;
      logic [17:0]        sdm_acc;
      logic               sdm_bit;
      logic [31:0]        prdata;
   } sdc_state_t;

   // Present state and the value it takes at the next edge
   sdc_state_t r_reg;
   sdc_state_t r_next;

   // Stage growth in bits per stage for a rate code: 5 at 64 kHz up to 8 at 8 kHz
   // Shared by the decimator format and the interpolator gain so both track one rate
   function automatic logic [3:0] stage_bits(input logic [1:0] rate);
      stage_bits = 4'h5 + {2'h0, rate};
   endfunction : stage_bits

   // Decimation ratio minus one for a rate code
   // At ratio 256 the ninth bit is dropped and the subtraction wraps to 255 on purpose
   function automatic logic [7:0] ratio_last(input logic [1:0] rate);
      logic [8:0] full;
      full = 9'h001 << stage_bits(rate);
      ratio_last = full[7:0] - 8'h01;
   endfunction : ratio_last

   // Turn the unipolar comb result into a 16-bit twos complement word
   // The comb counts ones, so half of full scale is the zero point; growth of 15 to 24
   // bits is aligned to bit 23 before the top 16 bits are kept
   function automatic logic [15:0] adc_format(input logic [25:0] acc, input logic [1:0] rate);
      logic [4:0]  growth;
      logic [25:0] half;
      logic [25:0] fs;
      logic [25:0] s;
      logic [25:0] sh;
      growth = 5'(3 * stage_bits(rate));
      half   = 26'h1 << (growth - 5'h1);
      fs     = 26'h1 << growth;
      s      = acc - half;                  // Centre on zero
      sh     = s << (5'd24 - growth);       // Align growth to 24 bits
      if (acc >= fs) begin
         adc_format = SDC_POS_FS;           // Positive full scale clamps
      end else begin
         adc_format = sh[23:8];             // Drop low bits, one zero at ratio 32
      end
   endfunction : adc_format

   // Clamp a wide signed value to a 16-bit DAC code
   // Interpolator overshoot on steps is clamped here rather than allowed to wrap
   function automatic logic [15:0] sat16(input logic signed [33:0] v);
      if (v > 34'sh0_0000_7fff) begin
         sat16 = SDC_POS_FS;
      end else if (v < -34'sh0_0000_8000) begin
         sat16 = SDC_NEG_FS;
      end else begin
         sat16 = v[15:0];
      end
   endfunction : sat16

   // Combinational helpers, all recomputed every cycle
   logic        mod_en;
   logic        smp;
   logic        mixed_on;
   logic        push;
   logic        pop;
   logic        wr_acc;
   logic        rd_setup;
   logic        mapped;
   logic [25:0] dc1;
   logic [25:0] dc2;
   logic [25:0] dc3;
   logic [15:0] adc_fmt;
   logic [15:0] adc_out;
   logic [33:0] x_in;
   logic [33:0] ic1;
   logic [33:0] ic2;
   logic [33:0] ic3;
   logic [33:0] iy;
   logic [15:0] sdm_x;
   logic [17:0] fb;
   logic [17:0] acc_n;
   logic [15:0] dac_take;
   logic [7:0]  gain_db;

   // Address decode and bus phases
   // Read data is fetched in the setup cycle, which lets PREADY stay high and every
   // transfer finish in two cycles
   always_comb begin
      wr_acc   = PSEL && PENABLE && PWRITE;
      rd_setup = PSEL && !PENABLE && !PWRITE;
      unique case (PADDR)
         SDC_SERIAL_MODE_OFF, SDC_RATE_OFF, SDC_GAIN_CTRL_OFF, SDC_FILT_CTRL_OFF,
         SDC_ADC_DATA_OFF, SDC_DAC_DATA_OFF, SDC_STATUS_OFF: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Mode decode and sample timing
   // The tick and the modulator enable come from one divider, so every rate shares its phase
   always_comb begin
      mixed_on = r_reg.mode_data && r_reg.mode_mixed;
      mod_en   = (r_reg.div == SDC_MOD_DIV_LAST);                     // Modulator rate tick
      smp      = mod_en && (r_reg.dec_cnt == ratio_last(r_reg.rate)); // One per N ticks
      gain_db  = SDC_GAIN_DB_TABLE[r_reg.gain];
   end

   // Decimator combs run once per output sample
   // Integrators and combs wrap modulo 2^26; the difference over one period is still exact
   // because the largest result, 256 cubed, fits with room to spare
   always_comb begin
      dc1     = r_reg.di3 - r_reg.dd1;
      dc2     = dc1 - r_reg.dd2;
      dc3     = dc2 - r_reg.dd3;
      adc_fmt = adc_format(dc3, r_reg.rate);
      if (mixed_on) begin
         adc_out = {1'b0, adc_fmt[15:1]};   // Flag low marks data, 15 bits left
      end else begin
         adc_out = adc_fmt;
      end
   end

   // Host word selection: mixed mode words with the flag set carry control, not audio
   // Data words lose their flag bit and shift up one place to keep full scale
   always_comb begin
      if (mixed_on) begin
         dac_take = {DAC_WORD[14:0], 1'b0};
      end else begin
         dac_take = DAC_WORD;
      end
   end

   // Interpolator combs at sample rate, integrators at modulator rate
   // Zero stuffing leaves a gain of N squared, taken out by a right shift of twice the
   // stage growth
   always_comb begin
      x_in = {{18{r_reg.dac_hold[15]}}, r_reg.dac_hold};
      ic1  = x_in - r_reg.cd1;
      ic2  = ic1 - r_reg.cd2;
      ic3  = ic2 - r_reg.cd3;
      iy   = 34'($signed(r_reg.ii3) >>> (5'({1'b0, stage_bits(r_reg.rate)}) << 1)); // Remove N squared gain
      if (r_reg.bypass) begin
         sdm_x = r_reg.dac_cur;             // Held word straight to modulator
      end else begin
         sdm_x = sat16(iy);
      end
   end

   // First order error feedback modulator
   // The accumulator stays within one full-scale step of zero, so 18 bits cannot wrap
   // for any 16-bit input, including both full-scale codes
   always_comb begin
      fb    = r_reg.sdm_bit ? SDC_SDM_POS : SDC_SDM_NEG;
      acc_n = r_reg.sdm_acc + {{2{sdm_x[15]}}, sdm_x} - fb;
   end

   // Two-entry output buffer handshakes
   // The decimator runs at a fixed rate and cannot wait, so a full buffer drops the
   // newest word and raises the overrun flag rather than stalling the filter
   always_comb begin
      pop  = ADC_VALID && ADC_READY;
      push = smp && r_reg.mode_data;        // Control mode sends no samples
   end

   // Next state
   always_comb begin
      r_next = r_reg;
      r_next.div = r_reg.div + 3'h1;
      // Integrators take the modulator bit at clock over eight
      // The modulator output moves on the same tick, so DAC_BIT changes at most every eighth clock
      if (mod_en) begin
         r_next.di1 = r_reg.di1 + {25'h0, MOD_BIT};
         r_next.di2 = r_reg.di2 + r_reg.di1;
         r_next.di3 = r_reg.di3 + r_reg.di2;
         r_next.dec_cnt = smp ? 8'h00 : r_reg.dec_cnt + 8'h01;
         r_next.ii1 = r_reg.ii1 + (smp ? ic3 : 34'h0); // Zero stuffing between samples
         r_next.ii2 = r_reg.ii2 + r_reg.ii1;
         r_next.ii3 = r_reg.ii3 + r_reg.ii2;
         r_next.sdm_acc = acc_n;
         r_next.sdm_bit = !acc_n[17];
      end
      // Sample period boundary
      // Combs and the held DAC word move only here, once per output period
      if (smp) begin
         r_next.dd1 = r_reg.di3;
         r_next.dd2 = dc1;
         r_next.dd3 = dc2;
         r_next.adc_word = adc_out;         // Held for a whole period
         r_next.cd1 = x_in;
         r_next.cd2 = ic1;
         r_next.cd3 = ic2;
         r_next.dac_cur = r_reg.dac_hold;   // Last word reused if none arrived
      end
      // Host word capture
      // A word that arrives between ticks waits in the hold register; the last one wins
      if (DAC_VALID && r_reg.mode_data && !(mixed_on && DAC_WORD[15])) begin
         r_next.dac_hold = dac_take;
      end
      // Output buffer
      // A pop and a push in one cycle keep the count and overwrite no live entry
      if (pop) begin
         r_next.rd_ptr = !r_reg.rd_ptr;
      end
      if (push && (r_reg.count != 2'h2 || pop)) begin
         r_next.fifo[r_reg.wr_ptr] = adc_out;
         r_next.wr_ptr = !r_reg.wr_ptr;
      end
      r_next.count = r_reg.count + ((push && (r_reg.count != 2'h2 || pop)) ? 2'h1 : 2'h0)
                     - (pop ? 2'h1 : 2'h0);
      // Register writes take effect at the access edge
      // Unmapped addresses fall into the default branch and change nothing
      if (wr_acc) begin
         unique case (PADDR)
            SDC_SERIAL_MODE_OFF: begin
               r_next.mode_data  = PWDATA[SDC_MODE_DATA_BIT];
               r_next.mode_mixed = PWDATA[SDC_MODE_MIXED_BIT];
            end
            SDC_RATE_OFF: begin
               // Restart the period so a shorter ratio does not wait for the counter to wrap
               r_next.rate    = PWDATA[1:0];
               r_next.dec_cnt = 8'h00;
            end
            SDC_GAIN_CTRL_OFF: r_next.gain   = PWDATA[2:0];
            SDC_FILT_CTRL_OFF: r_next.bypass = PWDATA[SDC_BYPASS_BIT];
            SDC_STATUS_OFF: begin
               if (PWDATA[SDC_OVR_BIT]) begin
                  r_next.overrun = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Overrun set wins over a clear in the same cycle
      if (push && r_reg.count == 2'h2 && !pop) begin
         r_next.overrun = 1'b1;
      end
      // Read data is captured in the setup cycle
      // Unused bits read as zero because the whole word is cleared first
      if (rd_setup) begin
         r_next.prdata = 32'h0;
         unique case (PADDR)
            SDC_SERIAL_MODE_OFF: r_next.prdata[1:0] = {r_reg.mode_mixed, r_reg.mode_data};
            SDC_RATE_OFF:        r_next.prdata[1:0] = r_reg.rate;
            SDC_GAIN_CTRL_OFF:   r_next.prdata[2:0] = r_reg.gain;
            SDC_FILT_CTRL_OFF:   r_next.prdata[SDC_BYPASS_BIT] = r_reg.bypass;
            SDC_ADC_DATA_OFF:    r_next.prdata[15:0] = r_reg.adc_word;
            SDC_DAC_DATA_OFF:    r_next.prdata[15:0] = r_reg.dac_cur;
            SDC_STATUS_OFF: begin
               r_next.prdata[SDC_OVR_BIT] = r_reg.overrun;
               r_next.prdata[2:1] = r_reg.count;
               r_next.prdata[SDC_GAIN_DB_LSB +: 8] = gain_db;
            end
            default: ;
         endcase
      end
   end

   // State register, synchronous reset
   // Clearing the whole struct first keeps every filter register defined; the
   // named fields then take their reset codes
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         r_reg      <= '0;
         r_reg.rate <= SDC_RATE_RST;
         r_reg.gain <= SDC_GAIN_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs
   // Stream handshakes are decoded from state, PREADY is tied high and PSLVERR decodes the bus; data outputs are register copies
   assign PREADY      = 1'b1;               // Setup already fetched the data
   assign PSLVERR     = PSEL && PENABLE && !mapped;
   assign PRDATA      = r_reg.prdata;
   assign DAC_BIT     = r_reg.sdm_bit;
   assign GAIN_SEL    = r_reg.gain;
   assign ADC_WORD    = r_reg.fifo[r_reg.rd_ptr];
   assign ADC_VALID   = (r_reg.count != 2'h0);
   assign DAC_READY   = r_reg.mode_data;
   assign SAMPLE_TICK = smp;

endmodule : sdc_filter_path

//--- tb/sdc_props.sv
// Purpose: Port checker for the codec filter path
// Assumes: Mode and gain are written over APB before data flows
// Notes:   Mode changes racing a sample tick are not excluded
`timescale 1ns/1ps
module sdc_props
   import sdc_pkg::*;
(
   // Clock and reset
   input wire logic        SYS_CLK,
   input wire logic        SRST,
   // APB slave
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [31:0] PRDATA,
   // Stream side
   input wire logic        DAC_BIT,
   input wire logic [2:0]  GAIN_SEL,
   input wire logic [15:0] ADC_WORD,
   input wire logic        ADC_VALID,
   input wire logic        ADC_READY,
   input wire logic        DAC_READY,
   input wire logic        SAMPLE_TICK
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   // Access phase of a transfer
   logic acc;
   assign acc = PSEL && PENABLE;
   // Mapped registers are the aligned words up to the status register
   logic mapped_a;
   assign mapped_a = (PADDR[1:0] == 2'h0) && (PADDR <= SDC_STATUS_OFF);
   a_ready_const: assert property (PREADY) else $error("ready low");
   a_unmapped_err: assert property (acc |-> PSLVERR == !mapped_a) else $error("bad slave error");
   a_unmapped_zero: assert property (acc && !PWRITE && !mapped_a |-> PRDATA == 32'h0)
      else $error("unmapped read not zero");
   a_mode_ready: assert property (acc && PWRITE && PADDR == 8'h00 |=> DAC_READY == $past(PWDATA[0]))
      else $error("mode not taken");
   a_gain_copy: assert property (acc && PWRITE && PADDR == 8'h08 |=> GAIN_SEL == $past(PWDATA[2:0]))
      else $error("gain not taken");
   a_adc_hold: assert property (ADC_VALID && !ADC_READY |=> ADC_VALID && $stable(ADC_WORD))
      else $error("word not held");
   a_dac_cadence: assert property ($changed(DAC_BIT) |=> $stable(DAC_BIT) [*7])
      else $error("dac bit too fast");
   a_ctrl_nopush: assert property (!DAC_READY && !ADC_VALID |=> !ADC_VALID)
      else $error("push in control mode");
   a_push_valid: assert property (SAMPLE_TICK && DAC_READY && !ADC_VALID |=> ADC_VALID)
      else $error("no word after tick");
   // Main scenarios reached
   c_push: cover property (SAMPLE_TICK && DAC_READY);
   c_stall: cover property ((ADC_VALID && !ADC_READY) [*4]);
   c_err: cover property (PSLVERR);
endmodule : sdc_props
bind sdc_filter_path sdc_props u_props (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
   .DAC_BIT(DAC_BIT), .GAIN_SEL(GAIN_SEL), .ADC_WORD(ADC_WORD), .ADC_VALID(ADC_VALID), .ADC_READY(ADC_READY),
   .DAC_READY(DAC_READY), .SAMPLE_TICK(SAMPLE_TICK));

//--- tb/sdc_host_model.sv
// Purpose: Host serial port model that drains ADC words and sends DAC words
// Assumes: Bench asks for a send with one-cycle send pulses
// Notes:   Idle DAC data toggles so a stale word is never mistaken for a fresh one
`timescale 1ns/1ps
module sdc_host_model (
   // Clock, reset and bench control
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        stall,
   input wire logic        send,
   input wire logic [15:0] word_in,
   // Stream pins
   input wire logic [15:0] adc_word,
   input wire logic        adc_valid,
   output logic            adc_ready,
   output logic            dac_valid,
   output logic [15:0]     dac_word,
   // Observed results
   output logic [15:0]     last_word,
   output logic [15:0]     n_pop
);
   // Drain, stall and send; words are twos complement both ways
   always_ff @(posedge clk) begin
      if (rst) begin
         adc_ready <= 1'b0;
         dac_valid <= 1'b0;
         dac_word  <= 16'h5a5a;
         n_pop     <= 16'h0;
      end else begin
         adc_ready <= !stall;
         dac_valid <= send;
         dac_word  <= send ? word_in : ~dac_word;
         if (adc_valid && adc_ready) begin
            last_word <= adc_word;
            n_pop     <= n_pop + 16'h1;
         end
      end
   end
endmodule : sdc_host_model

//--- tb/sdc_filter_path_test.sv
// Purpose: Self-checking bench for the codec filter path
// Assumes: Zero-wait APB slave; decimator words drained by the host model
// Notes:   Filter transients are skipped by discarding early words
`timescale 1ns/1ps
module sdc_filter_path_test;
   import sdc_pkg::*;
   logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, modb = 0, modv = 0, stall = 0, send = 0, rnd = 0, err;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, dacb, adcv, adcr, dacv, dacrdy, tick;
   logic [2:0] gsel;
   logic [15:0] adcw, dacw, win = 0, lastw, npop, w;
   int fails = 0, n_compared = 0, seed = 32'h2b8f6c55, k, n;
   always #25 clk = ~clk;
   // Modulator bit has one driver: random stream or the fixed level in modv
   always @(posedge clk) modb <= rnd ? 1'($random(seed)) : modv;
   sdc_filter_path dut (.SYS_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata), .MOD_BIT(modb), .DAC_BIT(dacb),
      .GAIN_SEL(gsel), .ADC_WORD(adcw), .ADC_VALID(adcv), .ADC_READY(adcr), .DAC_WORD(dacw), .DAC_VALID(dacv),
      .DAC_READY(dacrdy), .SAMPLE_TICK(tick));
   sdc_host_model host (.clk(clk), .rst(srst), .stall(stall), .send(send), .word_in(win), .adc_word(adcw),
      .adc_valid(adcv), .adc_ready(adcr), .dac_valid(dacv), .dac_word(dacw), .last_word(lastw), .n_pop(npop));
   function automatic logic [7:0] gain_db(input int c);
      int t [8] = '{0, 6, 12, 18, 20, 26, 32, 38};
      return t[c][7:0];
   endfunction : gain_db
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; read data and error taken at the access edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int t;
      psel <= 1; pen <= 0; pwr <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1;
      t = 0;
      do begin @(posedge clk); t++; end while (pready !== 1'b1 && t < 20);
      rd = prdata;
      err = pslverr;
      psel <= 0; pen <= 0;
      @(posedge clk); // Idle cycle so the next setup never reassigns psel at this edge
      if (t >= 20) begin fails++; finish_test(); end
   endtask : apb
   task automatic tick_wait(input int m);
      int t;
      repeat (m) begin
         t = 0;
         do begin @(posedge clk); t++; end while (tick !== 1'b1 && t < 5000);
         if (t >= 5000) begin fails++; finish_test(); end
      end
   endtask : tick_wait
   task automatic next_word(input int m);
      int t;
      repeat (m) begin
         w = npop; t = 0;
         while (npop === w && t < 9000) begin @(posedge clk); t++; end
         if (t >= 9000) begin fails++; finish_test(); end
      end
      w = lastw;
   endtask : next_word
   task automatic dac_send(input logic [15:0] v);
      send <= 1; win <= v;
      @(posedge clk);
      send <= 0;
      tick_wait(2);
      apb(0, SDC_DAC_DATA_OFF, 0);
   endtask : dac_send
   task automatic ones(output int c);
      c = 0;
      repeat (512) begin @(posedge clk); if (dacb === 1'b1) c++; end
   endtask : ones
   initial begin
      repeat (5) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      // Reset values, unmapped address
      for (k = 0; k < 7; k++) if (k < 3 || k == 6) begin apb(0, 8'(4 * k), 0); chk(rd, 0); end
      apb(0, 8'h1c, 0); chk(rd, 0); chk(err, 1);
      for (k = 0; k < 8; k++) begin
         apb(1, SDC_GAIN_CTRL_OFF, k); apb(0, SDC_STATUS_OFF, 0);
         chk({rd[15:8], gsel}, {gain_db(k), 3'(k)});
      end
      $display("registers done");
      // Every rate: tick spacing and full-scale saturation
      apb(1, SDC_SERIAL_MODE_OFF, 1); modv <= 1;
      for (k = 0; k < 4; k++) begin
         apb(1, SDC_RATE_OFF, k); tick_wait(2); n = 0;
         do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 5000);
         chk(n, 256 << k);
         next_word(5); chk(w, 16'h7fff);
      end
      apb(0, SDC_ADC_DATA_OFF, 0); chk(rd, 16'h7fff);
      apb(1, SDC_RATE_OFF, 0); modv <= 0; next_word(5); chk(w, 16'h8000);
      rnd <= 1;
      for (k = 0; k < 4; k++) begin next_word(1); chk(w[0] === 1'b0 || w === 16'h7fff, 1); end
      apb(1, SDC_SERIAL_MODE_OFF, 3); next_word(3);
      for (k = 0; k < 4; k++) begin next_word(1); chk(w[15], 0); end
      $display("decimator done");
      // Host stall fills the two-entry buffer until it drops
      stall <= 1; tick_wait(4); apb(0, SDC_STATUS_OFF, 0);
      chk({rd[2:0], adcv}, 4'hb);
      stall <= 0; apb(1, SDC_STATUS_OFF, 1); apb(0, SDC_STATUS_OFF, 0); chk(rd[0], 0);
      $display("buffer done");
      // DAC words, reuse, flag words, control mode, bypass
      apb(1, SDC_SERIAL_MODE_OFF, 1); w = 16'($random(seed));
      dac_send(w); chk(rd, w);
      tick_wait(1); apb(0, SDC_DAC_DATA_OFF, 0); chk(rd, w);
      apb(1, SDC_SERIAL_MODE_OFF, 3); dac_send(16'h8123); chk(rd, w);
      dac_send(16'h1234); chk(rd, 16'h2468);
      apb(1, SDC_SERIAL_MODE_OFF, 0); dac_send(16'h1111); chk(rd, 16'h2468);
      apb(1, SDC_SERIAL_MODE_OFF, 1); apb(1, SDC_FILT_CTRL_OFF, 32'h20);
      dac_send(16'h7fff); ones(n); chk(n >= 480, 1);
      dac_send(16'h8000); ones(n); chk(n <= 32, 1);
      apb(1, SDC_FILT_CTRL_OFF, 0); dac_send(16'h7fff); tick_wait(3);
      ones(n); chk(n >= 480, 1);
      $display("decoder done");
      finish_test();
   end
endmodule : sdc_filter_path_test
